// File: hdl/pohz_top.sv
/*
  Output high-impedance control for motor timer pins: fault request pin
  detection, complementary short detection, software shutdown, write-once
  enables and per-pin high-impedance controls behind a Wishbone slave.
  Assumes pin inputs synchronous to clk_i and a single 100 MHz clock.
*/
// What this block does
// - secondary pair both active sets short flag
// - short flag clears by read-1 then write-0
// - short flag with enable requests secondary hiz
// - short flag interrupt only when enabled
// - reserved bits read zero, write zero
// - write-once bits accept the first write only
// - channel-0 pin condition sets fault flag
// - edge mode flag clears by read-write
// - level mode clear waits for sampled high
// - channel-0 hiz enable gates fault flag
// - channel-0 interrupt only when enabled
// - mode 00 accepts falling edge
// - other modes need sixteen low samples
// - software bit shuts secondary pins
// - software bit shuts channel-0 pins
// - software bit shuts primary pins
// - per-pin enables gate channel-0 shutdown
// - primary pair enables compare and shut
// - disabled pair neither compares nor shuts
// - secondary pair enables shut on any cause
// - channel-0 pin hiz equation
`timescale 1ns/1ps
module pohz_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic channel0_request_pin_n_i,
  input wire logic [3:0] primary_fault_i,
  input wire logic [3:0] secondary_fault_i,
  input wire pohz_pkg::pohz_pair_type [2:0] primary_pairs_i,
  input wire pohz_pkg::pohz_pair_type [2:0] secondary_pairs_i,
  output logic [2:0] primary_pair_hiz_o,
  output logic [2:0] secondary_pair_hiz_o,
  output logic [3:0] channel0_pin_hiz_o,
  output logic secondary_short_irq_o,
  output logic channel0_fault_irq_o
);
  pohz_pkg::pohz_wb_req_type req;
  logic access;
  logic wr;
  logic rd;
  logic wr_lo;
  logic wr_hi;
  logic ack_ff;
  logic [31:0] rdata;

  logic secondary_short_flag_ff;
  logic primary_short_flag_ff;
  logic channel0_fault_flag_ff;
  logic [3:0] primary_fault_flag_ff;
  logic [3:0] secondary_fault_flag_ff;
  logic secondary_short_irq_enable_ff;
  logic channel0_fault_irq_enable_ff;
  logic sw_secondary_shutdown_ff;
  logic sw_channel0_shutdown_ff;
  logic sw_primary_shutdown_ff;
  // read-1 markers, set when software has seen a flag at 1
  logic sec_short_seen_ff;
  logic pri_short_seen_ff;
  logic ch0_seen_ff;
  logic sw_sec_seen_ff;
  logic sw_ch0_seen_ff;
  logic sw_pri_seen_ff;

  logic secondary_short_hiz_enable;
  logic primary_short_hiz_enable;
  logic channel0_fault_hiz_enable;
  logic [1:0] channel0_request_mode;
  logic [3:0] channel0_pin_enable;
  logic [2:0] primary_pair_enable;
  logic [2:0] secondary_pair_enable;

  logic pin_prev_ff;
  logic [6:0] div_cnt_ff;
  logic [4:0] low_run_ff;
  logic high_seen_ff;
  logic [6:0] div_last;
  logic sample_tick;
  logic ch0_event;
  logic sec_short_now;
  logic pri_short_now;
  logic cear_sec_short;
  logic clear_pri_short;
  logic clear_ch0;
  logic pri_cause;
  logic sec_cause;
  logic ch0_cause;

  // bus request packing
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                 adr: wb_adr_i, dat: wb_dat_i};
  assign access = req.cyc && req.stb && !ack_ff && ce_i;
  assign wr = access && req.we;
  assign rd = access && !req.we;
  assign wr_lo = wr && req.sel[0];
  assign wr_hi = wr && req.sel[1];

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else if (ce_i) begin
      ack_ff <= access;
    end
  end
  assign wb_ack_o = ack_ff;

  // write-once fields
  pohz_once #(.W(1)) u_sec_hiz (.clk_i(clk_i), .rst_i(rst_i),
    .wr_i(wr_hi && req.adr == pohz_pkg::ADDR_SEC_SHORT),
    .data_i(req.dat[pohz_pkg::SEC_SHORT_HIZ_BIT]), .value_o(secondary_short_hiz_enable));
  pohz_once #(.W(1)) u_pri_hiz (.clk_i(clk_i), .rst_i(rst_i),
    .wr_i(wr_hi && req.adr == pohz_pkg::ADDR_PRI_STAT),
    .data_i(req.dat[pohz_pkg::PRI_SHORT_HIZ_BIT]), .value_o(primary_short_hiz_enable));
  pohz_once #(.W(1)) u_ch0_hiz (.clk_i(clk_i), .rst_i(rst_i),
    .wr_i(wr_hi && req.adr == pohz_pkg::ADDR_CH0_REQ),
    .data_i(req.dat[pohz_pkg::CH0_HIZ_BIT]), .value_o(channel0_fault_hiz_enable));
  pohz_once #(.W(2)) u_ch0_mode (.clk_i(clk_i), .rst_i(rst_i),
    .wr_i(wr_lo && req.adr == pohz_pkg::ADDR_CH0_REQ),
    .data_i(req.dat[pohz_pkg::CH0_MODE_LSB +: 2]), .value_o(channel0_request_mode));
  pohz_once #(.W(4)) u_ch0_pins (.clk_i(clk_i), .rst_i(rst_i),
    .wr_i(wr_lo && req.adr == pohz_pkg::ADDR_CH0_PIN),
    .data_i(req.dat[3:0]), .value_o(channel0_pin_enable));
  pohz_once #(.W(3), .RESET_VALUE(pohz_pkg::PRI_PAIR_RESET)) u_pri_pairs (
    .clk_i(clk_i), .rst_i(rst_i),
    .wr_i(wr_hi && req.adr == pohz_pkg::ADDR_PAIR_EN),
    .data_i(req.dat[pohz_pkg::PRI_PAIR_LSB +: 3]), .value_o(primary_pair_enable));
  pohz_once #(.W(3), .RESET_VALUE(pohz_pkg::SEC_PAIR_RESET)) u_sec_pairs (
    .clk_i(clk_i), .rst_i(rst_i),
    .wr_i(wr_hi && req.adr == pohz_pkg::ADDR_PAIR_EN),
    .data_i(req.dat[pohz_pkg::SEC_PAIR_LSB +: 3]), .value_o(secondary_pair_enable));

  // plain interrupt enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      secondary_short_irq_enable_ff <= 1'b0;
      channel0_fault_irq_enable_ff <= 1'b0;
    end else if (wr_hi && req.adr == pohz_pkg::ADDR_SEC_SHORT) begin
      secondary_short_irq_enable_ff <= req.dat[pohz_pkg::SEC_SHORT_IRQ_BIT];
    end else if (wr_hi && req.adr == pohz_pkg::ADDR_CH0_REQ) begin
      channel0_fault_irq_enable_ff <= req.dat[pohz_pkg::CH0_IRQ_BIT];
    end
  end

  // short detection only on pairs whose enable is set
  always_comb begin
    sec_short_now = 1'b0;
    pri_short_now = 1'b0;
    for (int i = 0; i < 3; i++) begin
      sec_short_now |= secondary_pair_enable[i] &&
                       secondary_pairs_i[i].pos && secondary_pairs_i[i].neg;
      pri_short_now |= primary_pair_enable[i] &&
                       primary_pairs_i[i].pos && primary_pairs_i[i].neg;
    end
  end

  // a clear needs a prior read of 1 and a written 0; writing 1 does nothing
  assign cear_sec_short = wr_hi && req.adr == pohz_pkg::ADDR_SEC_SHORT &&
                          sec_short_seen_ff && !req.dat[pohz_pkg::SEC_SHORT_FLAG_BIT];
  assign clear_pri_short = wr_hi && req.adr == pohz_pkg::ADDR_PRI_STAT &&
                           pri_short_seen_ff && !req.dat[pohz_pkg::PRI_SHORT_FLAG_BIT];
  // level modes also need a high sample since the flag was set
  assign clear_ch0 = wr_hi && req.adr == pohz_pkg::ADDR_CH0_REQ && ch0_seen_ff &&
                     !req.dat[pohz_pkg::CH0_FLAG_BIT] &&
                     (channel0_request_mode == pohz_pkg::POHZ_MODE_EDGE ||
                      high_seen_ff);

  // short flags: a new short wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      secondary_short_flag_ff <= 1'b0;
      primary_short_flag_ff <= 1'b0;
    end else if (ce_i) begin
      if (sec_short_now) begin
        secondary_short_flag_ff <= 1'b1;
      end else if (cear_sec_short) begin
        secondary_short_flag_ff <= 1'b0;
      end
      if (pri_short_now) begin
        primary_short_flag_ff <= 1'b1;
      end else if (clear_pri_short) begin
        primary_short_flag_ff <= 1'b0;
      end
    end
  end

  // primary and secondary fault inputs are registered each cycle as level requests, read-only here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      primary_fault_flag_ff <= '0;
      secondary_fault_flag_ff <= '0;
    end else if (ce_i) begin
      primary_fault_flag_ff <= primary_fault_i;
      secondary_fault_flag_ff <= secondary_fault_i;
    end
  end

  // divided sampling clock for level modes
  always_comb begin
    unique case (pohz_pkg::pohz_mode_type'(channel0_request_mode))
      pohz_pkg::POHZ_MODE_EDGE: div_last = pohz_pkg::DIV8_LAST;
      pohz_pkg::POHZ_MODE_DIV8: div_last = pohz_pkg::DIV8_LAST;
      pohz_pkg::POHZ_MODE_DIV16: div_last = pohz_pkg::DIV16_LAST;
      pohz_pkg::POHZ_MODE_DIV128: div_last = pohz_pkg::DIV128_LAST;
    endcase
  end
  assign sample_tick = (div_cnt_ff == div_last);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt_ff <= '0;
    end else if (ce_i) begin
      div_cnt_ff <= sample_tick ? 7'h00 : div_cnt_ff + 7'h01;
    end
  end

  // low-run counter saturates at sixteen consecutive low samples
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_run_ff <= '0;
      pin_prev_ff <= 1'b1;
    end else if (ce_i) begin
      pin_prev_ff <= channel0_request_pin_n_i;
      if (sample_tick) begin
        if (channel0_request_pin_n_i) begin
          low_run_ff <= '0;
        end else if (low_run_ff != pohz_pkg::LOW_RUN_COUNT) begin
          low_run_ff <= low_run_ff + 5'h01;
        end
      end
    end
  end

  // request detection: edge in mode 00, sixteen low samples otherwise
  assign ch0_event = (channel0_request_mode == pohz_pkg::POHZ_MODE_EDGE) ?
                     (pin_prev_ff && !channel0_request_pin_n_i) :
                     (low_run_ff == pohz_pkg::LOW_RUN_COUNT);

  // channel-0 fault flag; set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      channel0_fault_flag_ff <= 1'b0;
    end else if (ce_i) begin
      if (ch0_event) begin
        channel0_fault_flag_ff <= 1'b1;
      end else if (clear_ch0) begin
        channel0_fault_flag_ff <= 1'b0;
      end
    end
  end

  // remembers a sampled high while the flag stands, for level-mode clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_seen_ff <= 1'b0;
    end else if (ce_i) begin
      if (!channel0_fault_flag_ff || ch0_event) begin
        high_seen_ff <= 1'b0;
      end else if (sample_tick && channel0_request_pin_n_i) begin
        high_seen_ff <= 1'b1;
      end
    end
  end

  // software shutdown bits: write 1 sets, write 0 after read 1 clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_secondary_shutdown_ff <= 1'b0;
      sw_channel0_shutdown_ff <= 1'b0;
      sw_primary_shutdown_ff <= 1'b0;
    end else if (wr_lo && req.adr == pohz_pkg::ADDR_SW_SHUT) begin
      if (req.dat[pohz_pkg::SW_SEC_BIT] || sw_sec_seen_ff) begin
        sw_secondary_shutdown_ff <= req.dat[pohz_pkg::SW_SEC_BIT];
      end
      if (req.dat[pohz_pkg::SW_CH0_BIT] || sw_ch0_seen_ff) begin
        sw_channel0_shutdown_ff <= req.dat[pohz_pkg::SW_CH0_BIT];
      end
      if (req.dat[pohz_pkg::SW_PRI_BIT] || sw_pri_seen_ff) begin
        sw_primary_shutdown_ff <= req.dat[pohz_pkg::SW_PRI_BIT];
      end
    end
  end

  // read-1 markers: armed by a read returning 1, consumed by a write there
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sec_short_seen_ff <= 1'b0;
      pri_short_seen_ff <= 1'b0;
      ch0_seen_ff <= 1'b0;
      sw_sec_seen_ff <= 1'b0;
      sw_ch0_seen_ff <= 1'b0;
      sw_pri_seen_ff <= 1'b0;
    end else if (access) begin
      if (req.adr == pohz_pkg::ADDR_SEC_SHORT) begin
        sec_short_seen_ff <= rd && secondary_short_flag_ff;
      end
      if (req.adr == pohz_pkg::ADDR_PRI_STAT) begin
        pri_short_seen_ff <= rd && primary_short_flag_ff;
      end
      if (req.adr == pohz_pkg::ADDR_CH0_REQ) begin
        ch0_seen_ff <= rd && channel0_fault_flag_ff;
      end
      if (req.adr == pohz_pkg::ADDR_SW_SHUT) begin
        sw_sec_seen_ff <= rd && sw_secondary_shutdown_ff;
        sw_ch0_seen_ff <= rd && sw_channel0_shutdown_ff;
        sw_pri_seen_ff <= rd && sw_primary_shutdown_ff;
      end
    end
  end

  // read mux; reserved and unmapped bits read as zero
  always_comb begin
    rdata = '0;
    unique case (req.adr)
      pohz_pkg::ADDR_SEC_SHORT: begin
        rdata[pohz_pkg::SEC_SHORT_FLAG_BIT] = secondary_short_flag_ff;
        rdata[pohz_pkg::SEC_SHORT_HIZ_BIT] = secondary_short_hiz_enable;
        rdata[pohz_pkg::SEC_SHORT_IRQ_BIT] = secondary_short_irq_enable_ff;
      end
      pohz_pkg::ADDR_CH0_REQ: begin
        rdata[pohz_pkg::CH0_FLAG_BIT] = channel0_fault_flag_ff;
        rdata[pohz_pkg::CH0_HIZ_BIT] = channel0_fault_hiz_enable;
        rdata[pohz_pkg::CH0_IRQ_BIT] = channel0_fault_irq_enable_ff;
        rdata[pohz_pkg::CH0_MODE_LSB +: 2] = channel0_request_mode;
      end
      pohz_pkg::ADDR_SW_SHUT: begin
        rdata[pohz_pkg::SW_SEC_BIT] = sw_secondary_shutdown_ff;
        rdata[pohz_pkg::SW_CH0_BIT] = sw_channel0_shutdown_ff;
        rdata[pohz_pkg::SW_PRI_BIT] = sw_primary_shutdown_ff;
      end
      pohz_pkg::ADDR_CH0_PIN: rdata[3:0] = channel0_pin_enable;
      pohz_pkg::ADDR_PAIR_EN: begin
        rdata[pohz_pkg::PRI_PAIR_LSB +: 3] = primary_pair_enable;
        rdata[pohz_pkg::SEC_PAIR_LSB +: 3] = secondary_pair_enable;
      end
      pohz_pkg::ADDR_PRI_STAT: begin
        rdata[pohz_pkg::PRI_SHORT_FLAG_BIT] = primary_short_flag_ff;
        rdata[pohz_pkg::PRI_SHORT_HIZ_BIT] = primary_short_hiz_enable;
        rdata[pohz_pkg::PRI_FAULT_LSB +: 4] = primary_fault_flag_ff;
        rdata[pohz_pkg::PRI_FAULT_LSB + 4 +: 4] = secondary_fault_flag_ff;
      end
      default: rdata = '0;
    endcase
  end

  // read data registered alongside ack so it is stable for the master
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (ce_i) begin
      wb_dat_o <= rd ? rdata : 32'h00000000;
    end
  end

  // high-impedance causes per pin group
  assign pri_cause = (|primary_fault_flag_ff) ||
                     (primary_short_flag_ff && primary_short_hiz_enable) ||
                     sw_primary_shutdown_ff;
  assign sec_cause = (|secondary_fault_flag_ff) ||
                     (secondary_short_flag_ff && secondary_short_hiz_enable) ||
                     sw_secondary_shutdown_ff;
  assign ch0_cause = (channel0_fault_flag_ff && channel0_fault_hiz_enable) ||
                     sw_channel0_shutdown_ff;

  // combinational so a fault tristates pins without extra delay
  assign primary_pair_hiz_o = primary_pair_enable & {3{pri_cause}};
  assign secondary_pair_hiz_o = secondary_pair_enable & {3{sec_cause}};
  assign channel0_pin_hiz_o = channel0_pin_enable & {4{ch0_cause}};

  // level interrupt requests
  assign secondary_short_irq_o = secondary_short_flag_ff &&
                                 secondary_short_irq_enable_ff;
  assign channel0_fault_irq_o = channel0_fault_flag_ff &&
                                channel0_fault_irq_enable_ff;
endmodule

// File: hdl/pohz_pkg.sv
/*
  Package for the port output high-impedance control block: register
  offsets, field positions, reset values, sampling constants and carriers.
  Assumes a 32-bit classic Wishbone slave port with word-aligned registers.
*/
package pohz_pkg;
  // register byte offsets
  localparam logic [4:0] ADDR_SEC_SHORT = 5'h00;
  localparam logic [4:0] ADDR_CH0_REQ = 5'h04;
  localparam logic [4:0] ADDR_SW_SHUT = 5'h08;
  localparam logic [4:0] ADDR_CH0_PIN = 5'h0C;
  localparam logic [4:0] ADDR_PAIR_EN = 5'h10;
  localparam logic [4:0] ADDR_PRI_STAT = 5'h14;

  // secondary short control/status fields
  localparam int SEC_SHORT_FLAG_BIT = 15;
  localparam int SEC_SHORT_HIZ_BIT = 9;
  localparam int SEC_SHORT_IRQ_BIT = 8;
  // channel-0 request control/status fields
  localparam int CH0_FLAG_BIT = 12;
  localparam int CH0_HIZ_BIT = 9;
  localparam int CH0_IRQ_BIT = 8;
  localparam int CH0_MODE_LSB = 0;
  // software shutdown fields
  localparam int SW_SEC_BIT = 2;
  localparam int SW_CH0_BIT = 1;
  localparam int SW_PRI_BIT = 0;
  // pair enable fields
  localparam int PRI_PAIR_LSB = 12;
  localparam int SEC_PAIR_LSB = 8;
  // primary status register of this block's own layout
  localparam int PRI_SHORT_FLAG_BIT = 15;
  localparam int PRI_SHORT_HIZ_BIT = 9;
  localparam int PRI_FAULT_LSB = 0;

  localparam logic [2:0] PRI_PAIR_RESET = 3'h7;
  localparam logic [2:0] SEC_PAIR_RESET = 3'h7;

  // channel-0 request modes
  typedef enum logic [1:0] {
    POHZ_MODE_EDGE = 2'b00,
    POHZ_MODE_DIV8 = 2'b01,
    POHZ_MODE_DIV16 = 2'b10,
    POHZ_MODE_DIV128 = 2'b11
  } pohz_mode_type;

  // sampling dividers and run length
  localparam logic [6:0] DIV8_LAST = 7'h07;
  localparam logic [6:0] DIV16_LAST = 7'h0F;
  localparam logic [6:0] DIV128_LAST = 7'h7F;
  localparam logic [4:0] LOW_RUN_COUNT = 5'h10;

  // one complementary output pair of a timer, active high
  typedef struct packed {
    logic pos;
    logic neg;
  } pohz_pair_type;

  // wishbone request carrier
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [4:0] adr;
    logic [31:0] dat;
  } pohz_wb_req_type;
endpackage

// File: hdl/pohz_once.sv
/*
  Write-once register field: takes the first write after reset, then holds.
  Assumes the caller gives a one-cycle write strobe already gated by enable.
*/
`timescale 1ns/1ps
module pohz_once #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VALUE = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [W-1:0] data_i,
  output logic [W-1:0] value_o
);
  logic done_ff;

  // first write loads, later writes are ignored until the next rst_i
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      value_o <= RESET_VALUE;
      done_ff <= 1'b0;
    end else if (wr_i && !done_ff) begin
      value_o <= data_i;
      done_ff <= 1'b1;
    end
  end
endmodule

// File: tb/pohz_checker.sv
/*
  Checker for pohz_top: bus handshake, read data and release of pin controls.
  Assumes one clock domain and a master that holds each request until ack.
*/
`timescale 1ns/1ps
module pohz_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [3:0] secondary_fault_i,
  input wire pohz_pkg::pohz_pair_type [2:0] secondary_pairs_i,
  input wire logic [2:0] primary_pair_hiz_o,
  input wire logic [2:0] secondary_pair_hiz_o,
  input wire logic [3:0] channel0_pin_hiz_o,
  input wire logic secondary_short_irq_o,
  input wire logic channel0_fault_irq_o
);
  logic sec_both;
  // a secondary pair with both sides active is the only pin cause of a short
  assign sec_both = (&secondary_pairs_i[0]) | (&secondary_pairs_i[1]) | (&secondary_pairs_i[2]);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
    else $error("upper read bits not zero");
  a_unmapped_zero: assert property (wb_ack_o && wb_adr_i > 5'h14 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_sw_reserved: assert property (wb_ack_o && wb_adr_i == pohz_pkg::ADDR_SW_SHUT
    |-> wb_dat_o[7:3] == 5'h0)
    else $error("software register reserved bits set");
  a_ch0_release: assert property ($fell(|channel0_pin_hiz_o) |-> wb_ack_o && wb_we_i)
    else $error("channel-0 hiz dropped without a write");
  a_short_release: assert property ($fell(secondary_short_irq_o)
    |-> wb_ack_o && wb_we_i)
    else $error("short interrupt dropped without a write");
  a_fault_irq_drop: assert property ($fell(channel0_fault_irq_o)
    |-> wb_ack_o && wb_we_i)
    else $error("fault interrupt dropped without a write");
  a_sec_raise: assert property ($rose(|secondary_pair_hiz_o) |-> wb_ack_o
    || $past(|secondary_fault_i) || $past(sec_both) || $past(sec_both, 2))
    else $error("secondary hiz raised without cause");
  a_reset_quiet: assert property ($fell(rst_i) |-> !wb_ack_o && primary_pair_hiz_o == 3'h0
    && secondary_pair_hiz_o == 3'h0 && channel0_pin_hiz_o == 4'h0
    && !secondary_short_irq_o && !channel0_fault_irq_o)
    else $error("outputs active after reset");
  c_short_irq: cover property (secondary_short_irq_o);
  c_ch0_hiz: cover property (&channel0_pin_hiz_o);
  c_unmapped: cover property (wb_ack_o && wb_adr_i > 5'h14);
endmodule

bind pohz_top pohz_checker i_pohz_checker (
  .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
  .secondary_fault_i, .secondary_pairs_i, .primary_pair_hiz_o, .secondary_pair_hiz_o,
  .channel0_pin_hiz_o, .secondary_short_irq_o, .channel0_fault_irq_o
);

// File: tb/pohz_partner.sv
/*
  Timer outputs and fault request pin as seen by the block.
  Assumes the bench commands shorts and requests; pin idles high (pull-up).
*/
`timescale 1ns/1ps
module pohz_partner (
  input wire logic clk_i,
  input wire logic req_low_i,
  input wire logic [2:0] pri_short_i,
  input wire logic [2:0] sec_short_i,
  output logic channel0_request_pin_n_o,
  output pohz_pkg::pohz_pair_type [2:0] primary_pairs_o,
  output pohz_pkg::pohz_pair_type [2:0] secondary_pairs_o
);
  logic phase_ff = 1'b0;
  // free-running pwm phase, so pairs toggle instead of sitting still
  always_ff @(posedge clk_i) begin
    phase_ff <= ~phase_ff;
  end
  // complementary unless a short is commanded, then both sides active
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      primary_pairs_o[k].pos = phase_ff | pri_short_i[k];
      primary_pairs_o[k].neg = ~phase_ff | pri_short_i[k];
      secondary_pairs_o[k].pos = phase_ff | sec_short_i[k];
      secondary_pairs_o[k].neg = ~phase_ff | sec_short_i[k];
    end
  end
  assign channel0_request_pin_n_o = ~req_low_i;
endmodule

// File: tb/pohz_top_tb.sv
/*
  Testbench for pohz_top: register reads and writes over Wishbone, pin causes.
  Assumes the partner model drives timer pairs and the request pin.
*/
`timescale 1ns/1ps
module pohz_top_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  pohz_pkg::pohz_wb_req_type req = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic req_low = 1'b0;
  logic [2:0] pri_short = 3'h0;
  logic [2:0] sec_short = 3'h0;
  logic [3:0] primary_fault_i = 4'h0;
  logic [3:0] secondary_fault_i = 4'h0;
  logic channel0_request_pin_n_i;
  pohz_pkg::pohz_pair_type [2:0] primary_pairs_i;
  pohz_pkg::pohz_pair_type [2:0] secondary_pairs_i;
  logic [2:0] primary_pair_hiz_o;
  logic [2:0] secondary_pair_hiz_o;
  logic [3:0] channel0_pin_hiz_o;
  logic secondary_short_irq_o;
  logic channel0_fault_irq_o;
  logic [31:0] pins;
  logic [31:0] rd;
  int fail_count = 0;
  int checked = 0;
  int div;

  pohz_top i_pohz_top (.clk_i, .rst_i, .ce_i, .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
    .wb_we_i(req.we), .wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat),
    .wb_dat_o, .wb_ack_o, .channel0_request_pin_n_i, .primary_fault_i, .secondary_fault_i,
    .primary_pairs_i, .secondary_pairs_i, .primary_pair_hiz_o, .secondary_pair_hiz_o,
    .channel0_pin_hiz_o, .secondary_short_irq_o, .channel0_fault_irq_o);
  pohz_partner i_pohz_partner (.clk_i, .req_low_i(req_low), .pri_short_i(pri_short),
    .sec_short_i(sec_short), .channel0_request_pin_n_o(channel0_request_pin_n_i),
    .primary_pairs_o(primary_pairs_i), .secondary_pairs_o(secondary_pairs_i));

  // all pin controls in one word: sec irq, ch0 irq, primary, secondary, channel-0
  assign pins = {20'h0, secondary_short_irq_o, channel0_fault_irq_o, primary_pair_hiz_o,
    secondary_pair_hiz_o, channel0_pin_hiz_o};

  // 100 MHz clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic summarize;
    $display("checks %0d failures %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // reads use pre-edge values, so the outcome never depends on process order
  task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    req <= '{1'b1, 1'b1, we, 4'hF, adr, dat};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    check(32'(n < 50), 32'h1);
    rd = wb_dat_o;
    req <= '0;
    @(posedge clk_i);
  endtask

  task automatic rdchk(input logic [4:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    check(rd, exp);
  endtask

  task automatic restart;
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // hang guard: the level-mode runs dominate, well under this span
  initial begin
    repeat (30000) @(posedge clk_i);
    fail_count++;
    summarize();
  end

  initial begin
    restart();
    rdchk(pohz_pkg::ADDR_PAIR_EN, 32'h7700);
    rdchk(pohz_pkg::ADDR_CH0_REQ, 32'h0);
    wb(1'b1, 5'h1C, 32'hFFFF);
    rdchk(5'h1C, 32'h0);
    wb(1'b1, pohz_pkg::ADDR_SW_SHUT, 32'h07);
    check(pins, 32'h3F0);
    wb(1'b1, pohz_pkg::ADDR_SW_SHUT, 32'h0);
    check(pins, 32'h3F0);
    rdchk(pohz_pkg::ADDR_SW_SHUT, 32'h7);
    wb(1'b1, pohz_pkg::ADDR_SW_SHUT, 32'h0);
    check(pins, 32'h0);
    pri_short <= 3'h1;
    repeat (3) @(posedge clk_i);
    pri_short <= 3'h0;
    rdchk(pohz_pkg::ADDR_PRI_STAT, 32'h8000);
    primary_fault_i <= 4'h2;
    repeat (3) @(posedge clk_i);
    check(pins, 32'h380);
    primary_fault_i <= 4'h0;
    secondary_fault_i <= 4'h8;
    repeat (3) @(posedge clk_i);
    check(pins, 32'h070);
    secondary_fault_i <= 4'h0;
    // write-once fields keep their first write
    wb(1'b1, pohz_pkg::ADDR_PAIR_EN, 32'h0700);
    wb(1'b1, pohz_pkg::ADDR_PAIR_EN, 32'h7700);
    rdchk(pohz_pkg::ADDR_PAIR_EN, 32'h0700);
    wb(1'b1, pohz_pkg::ADDR_CH0_PIN, 32'hF);
    wb(1'b1, pohz_pkg::ADDR_CH0_PIN, 32'h0);
    rdchk(pohz_pkg::ADDR_CH0_PIN, 32'hF);
    primary_fault_i <= 4'h1;
    repeat (3) @(posedge clk_i);
    check(pins, 32'h0);
    primary_fault_i <= 4'h0;
    wb(1'b1, pohz_pkg::ADDR_SW_SHUT, 32'h2);
    check(pins, 32'h00F);
    rdchk(pohz_pkg::ADDR_SW_SHUT, 32'h2);
    wb(1'b1, pohz_pkg::ADDR_SW_SHUT, 32'h0);
    // secondary short: irq enable toggled, then both wrong clears before the right one
    wb(1'b1, pohz_pkg::ADDR_SEC_SHORT, 32'h0300);
    sec_short <= 3'h4;
    repeat (3) @(posedge clk_i);
    sec_short <= 3'h0;
    repeat (2) @(posedge clk_i);
    check(pins, 32'h870);
    wb(1'b1, pohz_pkg::ADDR_SEC_SHORT, 32'h0200);
    check(pins, 32'h070);
    wb(1'b1, pohz_pkg::ADDR_SEC_SHORT, 32'h0300);
    rdchk(pohz_pkg::ADDR_SEC_SHORT, 32'h8300);
    wb(1'b1, pohz_pkg::ADDR_SEC_SHORT, 32'h8300);
    rdchk(pohz_pkg::ADDR_SEC_SHORT, 32'h8300);
    wb(1'b1, pohz_pkg::ADDR_SEC_SHORT, 32'h0300);
    check(pins, 32'h0);
    // edge mode: flag clears even while the pin is still low
    wb(1'b1, pohz_pkg::ADDR_CH0_REQ, 32'h0300);
    // frozen while ce_i is low, so the edge is only taken once it runs again
    ce_i <= 1'b0;
    req_low <= 1'b1;
    repeat (3) @(posedge clk_i);
    check(pins, 32'h0);
    ce_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check(pins, 32'h40F);
    rdchk(pohz_pkg::ADDR_CH0_REQ, 32'h1300);
    wb(1'b1, pohz_pkg::ADDR_CH0_REQ, 32'h0300);
    check(pins, 32'h0);
    req_low <= 1'b0;
    // level modes: sixteen low samples, clear only after a high sample
    for (int m = 1; m < 4; m++) begin
      div = (m == 1) ? 8 : (m == 2) ? 16 : 128;
      restart();
      wb(1'b1, pohz_pkg::ADDR_CH0_REQ, 32'h0100 | 32'(m));
      req_low <= 1'b1;
      repeat (15 * div - 2) @(posedge clk_i);
      check(pins, 32'h0);
      repeat (div + 10) @(posedge clk_i);
      check(pins, 32'h400);
      rdchk(pohz_pkg::ADDR_CH0_REQ, 32'h1100 | 32'(m));
      wb(1'b1, pohz_pkg::ADDR_CH0_REQ, 32'h0100);
      check(pins, 32'h400);
      req_low <= 1'b0;
      repeat (2 * div + 4) @(posedge clk_i);
      rdchk(pohz_pkg::ADDR_CH0_REQ, 32'h1100 | 32'(m));
      wb(1'b1, pohz_pkg::ADDR_CH0_REQ, 32'h0100 | 32'(m));
      check(pins, 32'h0);
    end
    summarize();
  end
endmodule
